// ### hw/osc_pkg.sv
// package: register map, field layout and timing constants of the oscillator control block
package osc_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [3:0] OSC_CTRL_OFS   = 4'h0;
   localparam logic [3:0] OSC_DIV_OFS    = 4'h4;
   localparam logic [3:0] OSC_TUNE_OFS   = 4'h8;
   localparam logic [3:0] OSC_UNLOCK_OFS = 4'hc;
   // oscillator_control field positions
   localparam int CUR_SRC_LSB  = 12;
   localparam int NEW_SRC_LSB  = 8;
   localparam int FREEZE_BIT   = 7;
   localparam int PIN_FRZ_BIT  = 6;
   localparam int PLL_LOCK_BIT = 5;
   localparam int FAIL_BIT     = 3;
   localparam int PRI_KEEP_BIT = 2;
   localparam int SEC_ON_BIT   = 1;
   localparam int SW_REQ_BIT   = 0;
   // clock_divider field positions
   localparam int RECOVER_BIT  = 15;
   localparam int RATIO_LSB    = 12;
   localparam int RATIO_ON_BIT = 11;
   localparam int POST_LSB     = 8;
   // frc_tuning field
   localparam int TRIM_LSB     = 0;
   // reset values
   localparam logic [15:0] DIV_RST  = 16'h0000;
   localparam logic [5:0]  TRIM_RST = 6'h00;
   // unlock keys, written to the unlock register one after another
   localparam logic [7:0] KEY_HI_A = 8'h78;
   localparam logic [7:0] KEY_HI_B = 8'h9a;
   localparam logic [7:0] KEY_LO_A = 8'h46;
   localparam logic [7:0] KEY_LO_B = 8'h57;
   // cycles of the new clock waited before the switch
   localparam logic [3:0] SETTLE_CYCLES = 4'ha;
   // postscaler code that divides by 256
   localparam logic [2:0] POST_MAX_CODE = 3'h7;
   // source codes
   localparam logic [2:0] SRC_FRC     = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI     = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] SRC_SEC     = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC    = 3'h5;
   localparam logic [2:0] SRC_RSVD    = 3'h6;
   localparam logic [2:0] SRC_FRC_DIV = 3'h7;

   // configuration fuses seen by the block
   typedef struct packed {
      logic       switch_monitor_fuse;
      logic       monitor_low_fuse;
      logic       one_way_pin_freeze_fuse;
      logic [2:0] initial_source_fuse;
      logic [1:0] primary_submode_fuse;
   } osc_fuse_type;

   // status from the analog oscillators
   typedef struct packed {
      logic       pll_locked;
      logic       osc_ready;
      logic       new_clk_tick;
      logic       fail_detect;
   } osc_ana_type;

   // controls to the analog oscillators
   typedef struct packed {
      logic [2:0] active_source;
      logic [2:0] starting_source;
      logic       start_new;
      logic       primary_sleep_keep;
      logic       secondary_osc_on;
      logic [1:0] primary_submode;
      logic [7:0] periph_ratio;
      logic [8:0] rc_divisor;
      logic [5:0] rc_trim;
   } osc_ctl_type;

   typedef enum logic [2:0] {
      SW_IDLE  = 3'b001,
      SW_START = 3'b010,
      SW_WAIT  = 3'b100
   } osc_sw_state_type;

   // true for sources that run through the pll
   function automatic logic osc_uses_pll(input logic [2:0] src);
      return (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
   endfunction
endpackage

// ### hw/osc_ctrl.sv
// oscillator selection, doze ratio, rc postscaler and trim control with axi4-lite registers
// Notes on behaviour
// - current source read-only in bits 14-12
// - new source writable in bits 10-8
// - new source resets from fuse value
// - freeze bit set-only, blocks new source writes
// - monitor fuse 0: selections never frozen
// - pin freeze changes only after unlock
// - pll lock flag zero during switches
// - fail flag set by monitor, cleared
// - bit 2 keeps primary in sleep
// - bit 1 enables secondary oscillator
// - switch request cleared when switch completes
// - recover-on-interrupt clears ratio enable
// - doze ratio power of two when enabled
// - postscaler divides rc, code 7 by 256
// - six-bit signed trim of rc frequency
// - primary submode fixed by fuses
// - switching only when switch fuse zero
// - switching off: new source ignored
// - switching off: request held at zero
// - equal sources abort the switch
// - wait start-up, lock for pll sources, ten cycles, switch
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl (
   // clock, reset, enable
   input  wire logic                  CLOCK_IN,
   input  wire logic                  RST_N_IN,
   input  wire logic                  CE_IN,
   // axi4-lite write address and data
   input  wire logic [3:0]            AWADDR_IN,
   input  wire logic                  AWVALID_IN,
   output logic                       AWREADY_OUT,
   input  wire logic [31:0]           WDATA_IN,
   input  wire logic [3:0]            WSTRB_IN,
   input  wire logic                  WVALID_IN,
   output logic                       WREADY_OUT,
   // axi4-lite write response
   output logic [1:0]                 BRESP_OUT,
   output logic                       BVALID_OUT,
   input  wire logic                  BREADY_IN,
   // axi4-lite read
   input  wire logic [3:0]            ARADDR_IN,
   input  wire logic                  ARVALID_IN,
   output logic                       ARREADY_OUT,
   output logic [31:0]                RDATA_OUT,
   output logic [1:0]                 RRESP_OUT,
   output logic                       RVALID_OUT,
   input  wire logic                  RREADY_IN,
   // fuses, analog status and interrupt event
   input  wire osc_pkg::osc_fuse_type FUSE_IN,
   input  wire osc_pkg::osc_ana_type  ANA_IN,
   input  wire logic                  IRQ_IN,
   // oscillator controls
   output osc_pkg::osc_ctl_type       CTL_OUT
);
   import osc_pkg::*;

   // register state
   logic [2:0]       cur_src_r;
   logic [2:0]       new_src_r;
   logic             freeze_r;
   logic             pin_frz_r;
   logic             fail_r;
   logic             pri_keep_r;
   logic             sec_on_r;
   logic             sw_req_r;
   logic [15:0]      div_r;
   logic [5:0]       trim_r;
   logic [1:0]       key_hi_r;
   logic [1:0]       key_lo_r;
   logic             fuse_load_r;
   osc_sw_state_type sw_st_r;
   logic [3:0]       settle_r;
   logic             start_r;
   // synchronised analog status and interrupt
   osc_ana_type      ana_s1_r;
   osc_ana_type      ana_s2_r;
   logic             irq_s1_r;
   logic             irq_s2_r;
   logic             tick_d_r;
   // bus state
   logic             aw_held_r;
   logic [3:0]       aw_addr_r;
   logic             w_held_r;
   logic [31:0]      w_data_r;
   logic [3:0]       w_strb_r;
   logic             bvalid_r;
   logic [1:0]       bresp_r;
   logic             rvalid_r;
   logic [31:0]      rdata_r;
   logic [1:0]       rresp_r;

   // bus decoding
   wire         aw_take   = CE_IN && AWVALID_IN && !aw_held_r;
   wire         w_take    = CE_IN && WVALID_IN && !w_held_r;
   wire         wr_go     = CE_IN && aw_held_r && w_held_r && !bvalid_r;
   wire         ar_take   = CE_IN && ARVALID_IN && !rvalid_r;
   wire         wr_ctrl   = wr_go && (aw_addr_r == OSC_CTRL_OFS);
   wire         wr_div    = wr_go && (aw_addr_r == OSC_DIV_OFS);
   wire         wr_tune   = wr_go && (aw_addr_r == OSC_TUNE_OFS);
   wire         wr_unlk   = wr_go && (aw_addr_r == OSC_UNLOCK_OFS) && w_strb_r[0];
   wire         wr_map    = wr_ctrl || wr_div || wr_tune || (aw_addr_r == OSC_UNLOCK_OFS);
   wire         hi_wr     = wr_ctrl && w_strb_r[1] && key_hi_r[1];
   wire         lo_wr     = wr_ctrl && w_strb_r[0] && key_lo_r[1];
   wire [7:0]   key       = w_data_r[7:0];
   // switching allowed only with the fuse programmed to 0
   wire         sw_enabled = !FUSE_IN.switch_monitor_fuse;
   // freeze only bites while the switch fuse is programmed to 1, with switching disabled
   wire         frozen    = freeze_r && FUSE_IN.switch_monitor_fuse;
   wire         sel_ok    = sw_enabled && !frozen;
   wire         tick_edge = ana_s2_r.new_clk_tick && !tick_d_r;
   wire         busy      = (sw_st_r != SW_IDLE);
   // lock reads 0 in non-pll modes and throughout a valid switch
   wire         pll_flag  = ana_s2_r.pll_locked && osc_uses_pll(cur_src_r) && !busy;
   // one completion term for sequencer and source register, so both agree
   wire         sw_done   = (sw_st_r == SW_WAIT) && (settle_r == 4'h0) && ana_s2_r.osc_ready
                            && (ana_s2_r.pll_locked || !osc_uses_pll(new_src_r));
   wire [15:0]  ctrl_rd   = {1'b0, cur_src_r, 1'b0, new_src_r, freeze_r, pin_frz_r,
                             pll_flag, 1'b0, fail_r, pri_keep_r, sec_on_r, sw_req_r};
   wire [15:0]  rd_mux    = (ARADDR_IN == OSC_CTRL_OFS) ? ctrl_rd :
                            (ARADDR_IN == OSC_DIV_OFS)  ? div_r :
                            (ARADDR_IN == OSC_TUNE_OFS) ? {10'h000, trim_r} : 16'h0000;
   wire         rd_map    = (ARADDR_IN == OSC_CTRL_OFS) || (ARADDR_IN == OSC_DIV_OFS)
                            || (ARADDR_IN == OSC_TUNE_OFS) || (ARADDR_IN == OSC_UNLOCK_OFS);
   // postscaler divisor: powers of two up to 64, then 256
   wire [2:0]   post_code = div_r[POST_LSB+:3];
   wire [8:0]   post_div  = (post_code == POST_MAX_CODE) ? 9'h100
                            : 9'(9'h001 << post_code);
   wire [2:0]   ratio_code = div_r[RATIO_ON_BIT] ? div_r[RATIO_LSB+:3] : 3'h0;

   // axi handshake outputs
   assign AWREADY_OUT = CE_IN && !aw_held_r;
   assign WREADY_OUT  = CE_IN && !w_held_r;
   assign ARREADY_OUT = CE_IN && !rvalid_r;
   assign BVALID_OUT  = bvalid_r;
   assign BRESP_OUT   = bresp_r;
   assign RVALID_OUT  = rvalid_r;
   assign RDATA_OUT   = rdata_r;
   assign RRESP_OUT   = rresp_r;

   // oscillator controls
   assign CTL_OUT.active_source      = cur_src_r;
   assign CTL_OUT.starting_source    = new_src_r;
   assign CTL_OUT.start_new          = start_r;
   assign CTL_OUT.primary_sleep_keep = pri_keep_r;
   assign CTL_OUT.secondary_osc_on   = sec_on_r;
   assign CTL_OUT.primary_submode    = FUSE_IN.primary_submode_fuse;
   assign CTL_OUT.periph_ratio       = 8'(8'h01 << ratio_code);
   assign CTL_OUT.rc_divisor         = post_div;
   assign CTL_OUT.rc_trim            = trim_r;

   // axi write channel capture and response
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_held_r  <= 1'b0;
         w_data_r  <= 32'h00000000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
      end else if (CE_IN) begin
         if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= AWADDR_IN;
         end
         if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= WDATA_IN;
            w_strb_r <= WSTRB_IN;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_map ? 2'h0 : 2'h2;
         end else if (bvalid_r && BREADY_IN) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // axi read channel
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= 2'h0;
      end else if (CE_IN) begin
         if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {16'h0000, rd_mux};
            rresp_r  <= rd_map ? 2'h0 : 2'h2;
         end else if (rvalid_r && RREADY_IN) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // synchronisers for analog status and interrupt event
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ana_s1_r <= '0;
         ana_s2_r <= '0;
         irq_s1_r <= 1'b0;
         irq_s2_r <= 1'b0;
         tick_d_r <= 1'b0;
      end else if (CE_IN) begin
         ana_s1_r <= ANA_IN;
         ana_s2_r <= ana_s1_r;
         irq_s1_r <= IRQ_IN;
         irq_s2_r <= irq_s1_r;
         tick_d_r <= ana_s2_r.new_clk_tick;
      end
   end

   // unlock key tracking: a key pair arms one following control write per byte
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         key_hi_r <= 2'h0;
         key_lo_r <= 2'h0;
      end else if (CE_IN && wr_go) begin
         key_hi_r <= 2'h0;
         key_lo_r <= 2'h0;
         if (wr_unlk && key == KEY_HI_A) key_hi_r <= 2'h1;
         if (wr_unlk && key == KEY_HI_B && key_hi_r == 2'h1) key_hi_r <= 2'h2;
         if (wr_unlk && key == KEY_LO_A) key_lo_r <= 2'h1;
         if (wr_unlk && key == KEY_LO_B && key_lo_r == 2'h1) key_lo_r <= 2'h2;
      end
   end

   // control bits; fuse values are caught by a clocked load after reset release
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         fuse_load_r <= 1'b1;
         new_src_r   <= SRC_FRC;
         cur_src_r   <= SRC_FRC;
         freeze_r    <= 1'b0;
         pin_frz_r   <= 1'b0;
         fail_r      <= 1'b0;
         pri_keep_r  <= 1'b0;
         sec_on_r    <= 1'b0;
         div_r       <= DIV_RST;
         trim_r      <= TRIM_RST;
      end else if (CE_IN) begin
         if (fuse_load_r) begin
            fuse_load_r <= 1'b0;
            new_src_r   <= FUSE_IN.initial_source_fuse;
            cur_src_r   <= FUSE_IN.initial_source_fuse;
         end else if (sw_done) begin
            cur_src_r <= new_src_r;
         end
         // with switching off the field stays writable until the freeze bit is set, but selects nothing
         if (hi_wr && !frozen && !busy)
            new_src_r <= w_data_r[NEW_SRC_LSB+:3];
         if (lo_wr) begin
            if (w_data_r[FREEZE_BIT])
               freeze_r <= 1'b1;
            if (!(FUSE_IN.one_way_pin_freeze_fuse && pin_frz_r))
               pin_frz_r <= w_data_r[PIN_FRZ_BIT];
            pri_keep_r <= w_data_r[PRI_KEEP_BIT];
            sec_on_r   <= w_data_r[SEC_ON_BIT];
         end
         // set wins over clear; a valid switch start clears it too
         if (ana_s2_r.fail_detect)
            fail_r <= 1'b1;
         else if ((lo_wr && !w_data_r[FAIL_BIT]) || sw_st_r == SW_START)
            fail_r <= 1'b0;
         // interrupt return to 1:1 wins over a simultaneous software write
         if (wr_div && w_strb_r[1])
            div_r <= {w_data_r[15:8], 8'h00};
         if (div_r[RECOVER_BIT] && irq_s2_r)
            div_r[RATIO_ON_BIT] <= 1'b0;
         if (wr_tune && w_strb_r[0])
            trim_r <= w_data_r[TRIM_LSB+:6];
      end
   end

   // clock switch sequencer
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sw_st_r  <= SW_IDLE;
         sw_req_r <= 1'b0;
         settle_r <= 4'h0;
         start_r  <= 1'b0;
      end else if (CE_IN) begin
         case (sw_st_r)
            SW_IDLE: begin
               start_r <= 1'b0;
               if (lo_wr && w_data_r[SW_REQ_BIT] && sel_ok && !fuse_load_r) begin
                  if (new_src_r == cur_src_r) begin
                     sw_req_r <= 1'b0;
                  end else begin
                     sw_req_r <= 1'b1;
                     sw_st_r  <= SW_START;
                  end
               end else if (!sw_enabled) begin
                  sw_req_r <= 1'b0;
               end
            end
            SW_START: begin
               start_r  <= 1'b1;
               settle_r <= SETTLE_CYCLES;
               sw_st_r  <= SW_WAIT;
            end
            SW_WAIT: begin
               // count only after start-up and, for pll sources, lock
               if (ana_s2_r.osc_ready && (ana_s2_r.pll_locked || !osc_uses_pll(new_src_r))) begin
                  if (sw_done) begin
                     sw_req_r <= 1'b0;
                     start_r  <= 1'b0;
                     sw_st_r  <= SW_IDLE;
                  end else if (tick_edge) begin
                     settle_r <= settle_r - 4'h1;
                  end
               end
            end
            default: begin
               sw_st_r <= SW_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### testbench/osc_ctrl_chk.sv
// port-level assertions for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl_chk (
   // clock and reset
   input wire logic                  CLOCK_IN,
   input wire logic                  RST_N_IN,
   // read channel
   input wire logic [3:0]            ARADDR_IN,
   input wire logic                  ARVALID_IN,
   input wire logic                  ARREADY_OUT,
   input wire logic [31:0]           RDATA_OUT,
   input wire logic [1:0]            RRESP_OUT,
   input wire logic                  RVALID_OUT,
   input wire logic                  RREADY_IN,
   // fuses and oscillator controls
   input wire osc_pkg::osc_fuse_type FUSE_IN,
   input wire osc_pkg::osc_ctl_type  CTL_OUT
);
   import osc_pkg::*;
   // one domain, so clock and reset are given once
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);
   // bus answers
   a_upper_zero: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0000)
      else $error("upper half of read data not zero");
   a_read_answer: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
      else $error("read answer late");
   a_rdata_hold: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
      else $error("read data dropped before taken");
   a_unlock_reads0: assert property (ARVALID_IN && ARREADY_OUT && ARADDR_IN == OSC_UNLOCK_OFS
      |=> RDATA_OUT == 32'h0 && RRESP_OUT == 2'b00)
      else $error("unlock register does not read zero");
   // oscillator controls
   a_submode_fuse: assert property (CTL_OUT.primary_submode == FUSE_IN.primary_submode_fuse)
      else $error("primary submode not taken from fuse");
   a_post_code: assert property ($onehot(CTL_OUT.rc_divisor) && !CTL_OUT.rc_divisor[7])
      else $error("postscaler divisor not legal");
   a_ratio_hot: assert property ($onehot(CTL_OUT.periph_ratio))
      else $error("peripheral ratio not a power of two");
   a_no_switch_off: assert property (FUSE_IN.switch_monitor_fuse |-> !CTL_OUT.start_new)
      else $error("switch started with switching disabled");
   // first edge after release loads the fuse source, so skip it
   a_fuse_source: assert property ($past(RST_N_IN) && FUSE_IN.switch_monitor_fuse
      |=> CTL_OUT.active_source == FUSE_IN.initial_source_fuse)
      else $error("source differs from fuse with switching off");
   a_switch_source: assert property ($past(RST_N_IN, 2) && $changed(CTL_OUT.active_source)
      |-> $past(CTL_OUT.start_new) && $past(CTL_OUT.starting_source) == CTL_OUT.active_source)
      else $error("source changed outside a switch");
endmodule
bind osc_ctrl osc_ctrl_chk u_chk (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .ARADDR_IN(ARADDR_IN),
   .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT),
   .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .FUSE_IN(FUSE_IN),
   .CTL_OUT(CTL_OUT));
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench of the oscillator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
   import osc_pkg::*;
   // block ports and bench state
   logic         CLOCK_IN = 1'b0, RST_N_IN = 1'b0, CE_IN = 1'b1, IRQ_IN = 1'b0;
   logic [3:0]   AWADDR_IN = 4'h0, WSTRB_IN = 4'h0, ARADDR_IN = 4'h0;
   logic [31:0]  WDATA_IN = 32'h0;
   logic         AWVALID_IN = 1'b0, WVALID_IN = 1'b0, BREADY_IN = 1'b0;
   logic         ARVALID_IN = 1'b0, RREADY_IN = 1'b0;
   logic         AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
   logic [1:0]   BRESP_OUT, RRESP_OUT, r;
   logic [31:0]  RDATA_OUT, d;
   logic [5:0]   v;
   osc_fuse_type FUSE_IN = 8'h00;
   osc_ana_type  ANA_IN = 4'h0;
   osc_ctl_type  CTL_OUT;
   int           failures = 0, tests_run = 0;
   osc_ctrl DUT (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .AWADDR_IN(AWADDR_IN),
      .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT), .WDATA_IN(WDATA_IN), .WSTRB_IN(WSTRB_IN),
      .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT), .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT),
      .BREADY_IN(BREADY_IN), .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN),
      .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT),
      .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .FUSE_IN(FUSE_IN), .ANA_IN(ANA_IN),
      .IRQ_IN(IRQ_IN), .CTL_OUT(CTL_OUT));
   always #2.5 CLOCK_IN = ~CLOCK_IN;
   // write; handshakes judged at the falling edge, where inputs are settled
   task automatic wr(input logic [3:0] a, input logic [31:0] x, input logic [3:0] s);
      logic aw_t, w_t, b_t;
      b_t = 1'b0;
      @(posedge CLOCK_IN);
      AWADDR_IN <= a;
      WDATA_IN <= x;
      WSTRB_IN <= s;
      AWVALID_IN <= 1'b1;
      WVALID_IN <= 1'b1;
      BREADY_IN <= 1'b1;
      while (!b_t) begin
         @(negedge CLOCK_IN);
         aw_t = AWVALID_IN & AWREADY_OUT;
         w_t = WVALID_IN & WREADY_OUT;
         b_t = BVALID_OUT & BREADY_IN;
         r = BRESP_OUT;
         @(posedge CLOCK_IN);
         if (aw_t) AWVALID_IN <= 1'b0;
         if (w_t) WVALID_IN <= 1'b0;
         if (b_t) BREADY_IN <= 1'b0;
      end
   endtask
   // read; ready comes a cycle late so the slave must hold its answer
   task automatic rd(input logic [3:0] a);
      logic ar_t, r_t, rv;
      r_t = 1'b0;
      @(posedge CLOCK_IN);
      ARADDR_IN <= a;
      ARVALID_IN <= 1'b1;
      while (!r_t) begin
         @(negedge CLOCK_IN);
         ar_t = ARVALID_IN & ARREADY_OUT;
         rv = RVALID_OUT;
         r_t = rv & RREADY_IN;
         d = RDATA_OUT;
         r = RRESP_OUT;
         @(posedge CLOCK_IN);
         if (ar_t) ARVALID_IN <= 1'b0;
         RREADY_IN <= rv & !r_t;
      end
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] e, input string m);
      rd(a);
      `CHK(d, e, m)
   endtask
   // key pair, then one control byte write
   task automatic keys(input logic hi);
      wr(OSC_UNLOCK_OFS, {24'h0, hi ? KEY_HI_A : KEY_LO_A}, 4'h1);
      wr(OSC_UNLOCK_OFS, {24'h0, hi ? KEY_HI_B : KEY_LO_B}, 4'h1);
   endtask
   task automatic hi_wr(input logic [2:0] s);
      keys(1'b1);
      wr(OSC_CTRL_OFS, {21'h0, s, 8'h00}, 4'h2);
   endtask
   task automatic lo_wr(input logic [7:0] x);
      keys(1'b0);
      wr(OSC_CTRL_OFS, {24'h0, x}, 4'h1);
   endtask
   // new-clock cycles, slow enough for the input synchronisers
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge CLOCK_IN);
         ANA_IN.new_clk_tick <= 1'b1;
         repeat (2) @(posedge CLOCK_IN);
         ANA_IN.new_clk_tick <= 1'b0;
         @(posedge CLOCK_IN);
      end
      repeat (6) @(posedge CLOCK_IN);
   endtask
   task automatic do_reset(input osc_fuse_type f);
      RST_N_IN <= 1'b0;
      FUSE_IN <= f;
      repeat (20) @(posedge CLOCK_IN);
      RST_N_IN <= 1'b1;
      repeat (2) @(posedge CLOCK_IN);
   endtask
   task automatic sw(input logic [2:0] o, input logic [2:0] s, input logic [7:0] lk);
      hi_wr(s);
      lo_wr(8'h81);
      rc(OSC_CTRL_OFS, {17'h0, o, 1'b0, s, 8'h81}, "control during switch");
      `CHK(CTL_OUT.start_new, 1'b1, "switch not started")
      `CHK(CTL_OUT.starting_source, s, "starting source")
      ticks(9);
      `CHK(CTL_OUT.active_source, o, "switched early")
      ticks(1);
      `CHK(CTL_OUT.active_source, s, "switch not done")
      rc(OSC_CTRL_OFS, {17'h0, s, 1'b0, s, 8'h80 | lk}, "control after switch");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the tests need
   initial begin
      #250000;
      failures++;
      $display("wrong value at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      // switching disabled by fuse, one-way pin freeze
      do_reset({1'b1, 1'b0, 1'b1, SRC_FRC_DIV, 2'h1});
      rc(OSC_CTRL_OFS, 32'h7700, "control reset");
      rc(OSC_DIV_OFS, 32'h0, "divider reset");
      rc(OSC_TUNE_OFS, 32'h0, "trim reset");
      wr(OSC_CTRL_OFS, 32'h06, 4'h1);
      rc(OSC_CTRL_OFS, 32'h7700, "write without keys");
      hi_wr(SRC_FRC);
      lo_wr(8'h01);
      rc(OSC_CTRL_OFS, 32'h7000, "request with switching off");
      lo_wr(8'hc6);
      rc(OSC_CTRL_OFS, 32'h70c6, "low byte");
      `CHK({CTL_OUT.primary_sleep_keep, CTL_OUT.secondary_osc_on}, 2'b11, "sleep keep")
      hi_wr(SRC_PRI_PLL);
      rc(OSC_CTRL_OFS, 32'h70c6, "frozen selection");
      lo_wr(8'h00);
      rc(OSC_CTRL_OFS, 32'h70c0, "set-only bits");
      `CHK({CTL_OUT.primary_sleep_keep, CTL_OUT.secondary_osc_on}, 2'b00, "sleep off")
      $display("test fuse_off done");
      // switching and monitor enabled
      ANA_IN <= 4'hc;
      do_reset({1'b0, 1'b0, 1'b0, SRC_FRC, 2'h2});
      rc(OSC_CTRL_OFS, 32'h0, "control reset");
      wr(OSC_CTRL_OFS, 32'h40, 4'h1);
      rc(OSC_CTRL_OFS, 32'h0, "pin freeze without keys");
      lo_wr(8'h40);
      rc(OSC_CTRL_OFS, 32'h40, "pin freeze set");
      lo_wr(8'h00);
      rc(OSC_CTRL_OFS, 32'h0, "pin freeze clear");
      ANA_IN.fail_detect <= 1'b1;
      repeat (4) @(posedge CLOCK_IN);
      ANA_IN.fail_detect <= 1'b0;
      rc(OSC_CTRL_OFS, 32'h08, "fail flag set");
      lo_wr(8'h00);
      rc(OSC_CTRL_OFS, 32'h0, "fail flag clear");
      lo_wr(8'h80);
      sw(SRC_FRC, SRC_PRI, 8'h00);
      sw(SRC_PRI, SRC_PRI_PLL, 8'h20);
      sw(SRC_PRI_PLL, SRC_FRC, 8'h00);
      hi_wr(SRC_FRC);
      lo_wr(8'h81);
      rc(OSC_CTRL_OFS, 32'h80, "equal sources");
      `CHK(CTL_OUT.start_new, 1'b0, "abort started")
      $display("test switch done");
      // divider, recovery, trim, unmapped place
      for (int c = 0; c < 8; c++) begin
         wr(OSC_DIV_OFS, {17'h0, 3'(c), 1'b1, 3'(c), 8'hff}, 4'h3);
         rc(OSC_DIV_OFS, {17'h0, 3'(c), 1'b1, 3'(c), 8'h00}, "divider");
         `CHK(CTL_OUT.periph_ratio, 8'h01 << c, "ratio")
         `CHK(CTL_OUT.rc_divisor, (c == 7) ? 9'h100 : 9'h001 << c, "postscaler")
      end
      wr(OSC_DIV_OFS, 32'h7000, 4'h3);
      rc(OSC_DIV_OFS, 32'h7000, "ratio off");
      `CHK(CTL_OUT.periph_ratio, 8'h01, "ratio off")
      wr(OSC_DIV_OFS, 32'hb800, 4'h3);
      IRQ_IN <= 1'b1;
      repeat (4) @(posedge CLOCK_IN);
      IRQ_IN <= 1'b0;
      rd(OSC_DIV_OFS);
      `CHK({d[15], d[11]}, 2'b10, "recover")
      `CHK(CTL_OUT.periph_ratio, 8'h01, "recover ratio")
      for (int i = 0; i < 2; i++) begin
         v = (i == 0) ? 6'h20 : 6'h1f;
         wr(OSC_TUNE_OFS, {26'h3ffffff, v}, 4'hf);
         rc(OSC_TUNE_OFS, {26'h0, v}, "trim");
         `CHK(CTL_OUT.rc_trim, v, "trim out")
      end
      rc(OSC_UNLOCK_OFS, 32'h0, "unlock reads zero");
      wr(4'h2, 32'h0, 4'hf);
      `CHK(r, 2'b10, "unmapped write")
      rd(4'h2);
      `CHK(r, 2'b10, "unmapped read")
      $display("test divider done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
